// >>> rtl/ocd_decoder.sv
// instruction decoder for transfer, arithmetic and shift/rotate groups
`timescale 1ns/1ps
module ocd_decoder
  import ocd_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  input  wire logic       byte_valid_in,
  input  wire logic [7:0] byte_in,
  output logic            dec_valid_out,
  output ocd_op_e         dec_op_out,
  output ocd_sr_e         dec_sr_out,
  output logic            dec_word_out,
  output logic            dec_reg_dest_out,
  output logic            dec_count_reg_out,
  output logic            dec_sext_imm_out,
  output logic [1:0]      dec_imm_bytes_out,
  output logic [1:0]      dec_mode_out,
  output logic [2:0]      dec_reg_out,
  output logic [2:0]      dec_rm_out,
  output logic            dec_illegal_out
);

  ocd_if cls_bus ();

  ocd_first_class u_cls (
    .byte_in (byte_in),
    .cls_out (cls_bus.cls)
  );

  // held context of the first byte while the second is awaited
  ocd_st_e    st_q,      st_d;
  logic [7:0] first_q,   first_d;
  ocd_op_e    pend_op_q, pend_op_d;
  logic       unary_q,   unary_d;
  logic       shift_q,   shift_d;
  logic       imm_q,     imm_d;
  logic       pair_q,    pair_d;
  logic       has_d_q,   has_d_d;

  // registered outputs
  logic       vld_q,   vld_d;
  ocd_op_e    op_q,    op_d;
  ocd_sr_e    sr_q,    sr_d;
  logic       word_q,  word_d;
  logic       dest_q,  dest_d;
  logic       cnt_q,   cnt_d;
  logic       sext_q,  sext_d;
  logic [1:0] imm_n_q, imm_n_d;
  logic [1:0] mode_q,  mode_d;
  logic [2:0] reg_q,   reg_d;
  logic [2:0] rm_q,    rm_d;
  logic       ill_q,   ill_d;

  logic [2:0] mid;

  always_comb begin
    st_d      = st_q;
    first_d   = first_q;
    pend_op_d = pend_op_q;
    unary_d   = unary_q;
    shift_d   = shift_q;
    imm_d     = imm_q;
    pair_d    = pair_q;
    has_d_d   = has_d_q;
    vld_d     = 1'b0;
    op_d      = op_q;
    sr_d      = sr_q;
    word_d    = word_q;
    dest_d    = dest_q;
    cnt_d     = cnt_q;
    sext_d    = sext_q;
    imm_n_d   = imm_n_q;
    mode_d    = mode_q;
    reg_d     = reg_q;
    rm_d      = rm_q;
    ill_d     = 1'b0;
    mid       = byte_in[OCD_REG_LO +: 3];
    if (byte_valid_in) begin
      unique case (st_q)
        OCD_ST_FIRST: begin
          first_d   = byte_in;
          pend_op_d = cls_bus.op;
          unary_d   = cls_bus.grp_unary;
          shift_d   = cls_bus.grp_shift;
          imm_d     = cls_bus.grp_imm;
          pair_d    = cls_bus.adj_pair;
          has_d_d   = cls_bus.has_d;
          if (cls_bus.needs_modrm || cls_bus.adj_pair) begin
            st_d = OCD_ST_SECOND;
          end else begin
            // single-byte forms finish on their only byte
            vld_d   = 1'b1;
            op_d    = cls_bus.op;
            ill_d   = (cls_bus.op == OCD_OP_ILLEGAL);
            word_d  = 1'b0;
            dest_d  = 1'b0;
            cnt_d   = 1'b0;
            sext_d  = 1'b0;
            imm_n_d = 2'h0;
            mode_d  = 2'h0;
            reg_d   = 3'h0;
            rm_d    = 3'h0;
            sr_d    = OCD_SR_LROT;
          end
        end
        OCD_ST_SECOND: begin
          st_d    = OCD_ST_FIRST;
          vld_d   = 1'b1;
          op_d    = pend_op_q;
          sr_d    = ocd_sr_e'(mid);
          mode_d  = byte_in[OCD_MOD_LO +: 2];
          reg_d   = mid;
          rm_d    = byte_in[2:0];
          word_d  = first_q[OCD_W_BIT];
          dest_d  = has_d_q & first_q[OCD_D_BIT];
          cnt_d   = shift_q & first_q[OCD_D_BIT];
          sext_d  = 1'b0;
          imm_n_d = 2'h0;
          if (pair_q) begin
            // correction pair needs the fixed base byte second
            mode_d = 2'h0;
            reg_d  = 3'h0;
            rm_d   = 3'h0;
            word_d = 1'b0;
            if (byte_in != OCD_ADJ_BASE) begin
              op_d  = OCD_OP_ILLEGAL;
              ill_d = 1'b1;
            end
          end else if (pend_op_q == OCD_OP_COPY_TO_SEG ||
                       pend_op_q == OCD_OP_COPY_FR_SEG) begin
            // segment field is two bits behind a zero
            word_d = 1'b1;
            if (mid[2]) begin
              op_d  = OCD_OP_ILLEGAL;
              ill_d = 1'b1;
            end
          end else if (unary_q) begin
            unique case (mid)
              3'h2: op_d = OCD_OP_INVERT;
              3'h3: op_d = OCD_OP_SIGN_CHANGE;
              3'h4: op_d = OCD_OP_UPROD;
              3'h5: op_d = OCD_OP_SPROD;
              3'h6: op_d = OCD_OP_UQUOT;
              3'h7: op_d = OCD_OP_SQUOT;
              default: begin
                // field 000 (test with data) is not decoded here
                op_d  = OCD_OP_ILLEGAL;
                ill_d = 1'b1;
              end
            endcase
          end else if (shift_q) begin
            // 110 has no documented meaning; flagged
            if (mid == OCD_SR_RSV) begin
              op_d  = OCD_OP_ILLEGAL;
              ill_d = 1'b1;
            end
            // other shift and rotate codes pass through
          end else if (imm_q) begin
            // s sits in the d position for this group
            sext_d  = first_q[OCD_D_BIT];
            imm_n_d = (!first_q[OCD_D_BIT] && first_q[OCD_W_BIT]) ?
                      2'h2 : 2'h1;
          end
        end
        default: st_d = OCD_ST_FIRST;
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q      <= OCD_ST_FIRST;
      first_q   <= 8'h00;
      pend_op_q <= OCD_OP_NONE;
      unary_q   <= 1'b0;
      shift_q   <= 1'b0;
      imm_q     <= 1'b0;
      pair_q    <= 1'b0;
      has_d_q   <= 1'b0;
      vld_q     <= 1'b0;
      op_q      <= OCD_OP_NONE;
      sr_q      <= OCD_SR_LROT;
      word_q    <= 1'b0;
      dest_q    <= 1'b0;
      cnt_q     <= 1'b0;
      sext_q    <= 1'b0;
      imm_n_q   <= 2'h0;
      mode_q    <= 2'h0;
      reg_q     <= 3'h0;
      rm_q      <= 3'h0;
      ill_q     <= 1'b0;
    end else begin
      st_q      <= st_d;
      first_q   <= first_d;
      pend_op_q <= pend_op_d;
      unary_q   <= unary_d;
      shift_q   <= shift_d;
      imm_q     <= imm_d;
      pair_q    <= pair_d;
      has_d_q   <= has_d_d;
      vld_q     <= vld_d;
      op_q      <= op_d;
      sr_q      <= sr_d;
      word_q    <= word_d;
      dest_q    <= dest_d;
      cnt_q     <= cnt_d;
      sext_q    <= sext_d;
      imm_n_q   <= imm_n_d;
      mode_q    <= mode_d;
      reg_q     <= reg_d;
      rm_q      <= rm_d;
      ill_q     <= ill_d;
    end
  end

  assign dec_valid_out     = vld_q;
  assign dec_op_out        = op_q;
  assign dec_sr_out        = sr_q;
  assign dec_word_out      = word_q;
  assign dec_reg_dest_out  = dest_q;
  assign dec_count_reg_out = cnt_q;
  assign dec_sext_imm_out  = sext_q;
  assign dec_imm_bytes_out = imm_n_q;
  assign dec_mode_out      = mode_q;
  assign dec_reg_out       = reg_q;
  assign dec_rm_out        = rm_q;
  assign dec_illegal_out   = ill_q;

endmodule

// >>> rtl/ocd_first_class.sv
// combinational classifier for the first instruction byte
`timescale 1ns/1ps
module ocd_first_class
  import ocd_pkg::*;
(
  input  wire logic [7:0] byte_in,
  ocd_if.cls              cls_out
);

  always_comb begin
    cls_out.op          = OCD_OP_NONE;
    cls_out.needs_modrm = 1'b0;
    cls_out.grp_unary   = 1'b0;
    cls_out.grp_shift   = 1'b0;
    cls_out.grp_imm     = 1'b0;
    cls_out.adj_pair    = 1'b0;
    cls_out.has_d       = 1'b0;
    unique case (byte_in)
      OCD_SEG_IN:       begin
        cls_out.op          = OCD_OP_COPY_TO_SEG;
        cls_out.needs_modrm = 1'b1;
      end
      OCD_SEG_OUT:      begin
        cls_out.op          = OCD_OP_COPY_FR_SEG;
        cls_out.needs_modrm = 1'b1;
      end
      OCD_LOOKUP:       cls_out.op = OCD_OP_LOOKUP;
      OCD_EA_LOAD:      begin
        cls_out.op          = OCD_OP_EA_LOAD;
        cls_out.needs_modrm = 1'b1;
      end
      OCD_FAR_DSEG:     begin
        cls_out.op          = OCD_OP_FAR_DSEG;
        cls_out.needs_modrm = 1'b1;
      end
      OCD_FAR_ESEG:     begin
        cls_out.op          = OCD_OP_FAR_ESEG;
        cls_out.needs_modrm = 1'b1;
      end
      OCD_FLAGS_TO_ACC: cls_out.op = OCD_OP_FLAGS_ACC;
      OCD_ACC_TO_FLAGS: cls_out.op = OCD_OP_ACC_FLAGS;
      OCD_UNP_SUM:      cls_out.op = OCD_OP_UNP_SUM;
      OCD_BCD_SUM:      cls_out.op = OCD_OP_BCD_SUM;
      OCD_UNP_DIFF:     cls_out.op = OCD_OP_UNP_DIFF;
      OCD_BCD_DIFF:     cls_out.op = OCD_OP_BCD_DIFF;
      OCD_UNP_PROD:     begin
        cls_out.op       = OCD_OP_UNP_PROD;
        cls_out.adj_pair = 1'b1;
      end
      OCD_UNP_QUOT:     begin
        cls_out.op       = OCD_OP_UNP_QUOT;
        cls_out.adj_pair = 1'b1;
      end
      OCD_BYTE_EXT:     cls_out.op = OCD_OP_BYTE_EXT;
      OCD_WORD_EXT:     cls_out.op = OCD_OP_WORD_EXT;
      default: begin
        cls_out.needs_modrm = 1'b1;
        cls_out.has_d       = 1'b1;
        if (byte_in[7:2] == OCD_SUM_RM) begin
          cls_out.op = OCD_OP_SUM;
        end else if (byte_in[7:2] == OCD_SUMC_RM) begin
          cls_out.op = OCD_OP_SUM_CARRY;
        end else if (byte_in[7:2] == OCD_DIFF_RM) begin
          cls_out.op = OCD_OP_DIFF;
        end else if (byte_in[7:2] == OCD_DIFFB_RM) begin
          cls_out.op = OCD_OP_DIFF_BORROW;
        end else if (byte_in[7:2] == OCD_COMPARE_RM) begin
          cls_out.op = OCD_OP_COMPARE;
        end else begin
          cls_out.has_d = 1'b0;
          if (byte_in[7:1] == OCD_UNARY_GRP) begin
            cls_out.grp_unary = 1'b1;
          end else if (byte_in[7:2] == OCD_SHIFT_GRP) begin
            cls_out.op        = OCD_OP_SHIFT_ROT;
            cls_out.grp_shift = 1'b1;
          end else if (byte_in[7:2] == OCD_IMM_GRP) begin
            cls_out.op      = OCD_OP_IMM_ARITH;
            cls_out.grp_imm = 1'b1;
          end else begin
            // outside this decoder's groups
            cls_out.op          = OCD_OP_ILLEGAL;
            cls_out.needs_modrm = 1'b0;
          end
        end
      end
    endcase
  end

endmodule

// >>> rtl/ocd_if.sv
// first-byte classification carried from classifier to the sequencer
`timescale 1ns/1ps
interface ocd_if;
  import ocd_pkg::*;
  ocd_op_e    op;
  logic       needs_modrm;
  logic       grp_unary;
  logic       grp_shift;
  logic       grp_imm;
  logic       adj_pair;
  logic       has_d;
  modport cls (output op, needs_modrm, grp_unary, grp_shift, grp_imm,
               adj_pair, has_d);
  modport seq (input  op, needs_modrm, grp_unary, grp_shift, grp_imm,
               adj_pair, has_d);
endinterface

// >>> rtl/ocd_pkg.sv
// constants and types shared by the instruction decoder files
package ocd_pkg;

  // first-byte patterns and the adjust base second byte, full byte compares
  localparam logic [7:0] OCD_SEG_IN       = 8'h8E;
  localparam logic [7:0] OCD_SEG_OUT      = 8'h8C;
  localparam logic [7:0] OCD_LOOKUP       = 8'hD7;
  localparam logic [7:0] OCD_EA_LOAD      = 8'h8D;
  localparam logic [7:0] OCD_FAR_DSEG     = 8'hC5;
  localparam logic [7:0] OCD_FAR_ESEG     = 8'hC4;
  localparam logic [7:0] OCD_FLAGS_TO_ACC = 8'h9F;
  localparam logic [7:0] OCD_ACC_TO_FLAGS = 8'h9E;
  localparam logic [7:0] OCD_UNP_SUM      = 8'h37;
  localparam logic [7:0] OCD_BCD_SUM      = 8'h27;
  localparam logic [7:0] OCD_UNP_DIFF     = 8'h3F;
  localparam logic [7:0] OCD_BCD_DIFF     = 8'h2F;
  localparam logic [7:0] OCD_UNP_PROD     = 8'hD4;
  localparam logic [7:0] OCD_UNP_QUOT     = 8'hD5;
  localparam logic [7:0] OCD_ADJ_BASE     = 8'h0A;
  localparam logic [7:0] OCD_BYTE_EXT     = 8'h98;
  localparam logic [7:0] OCD_WORD_EXT     = 8'h99;

  // first-byte patterns on bits 7:2 (low bits are d/w, s/w or v/w)
  localparam logic [5:0] OCD_SUM_RM       = 6'h00;
  localparam logic [5:0] OCD_SUMC_RM      = 6'h04;
  localparam logic [5:0] OCD_DIFF_RM      = 6'h0A;
  localparam logic [5:0] OCD_DIFFB_RM     = 6'h06;
  localparam logic [5:0] OCD_COMPARE_RM   = 6'h0E;
  localparam logic [5:0] OCD_IMM_GRP      = 6'h20;
  localparam logic [5:0] OCD_SHIFT_GRP    = 6'h34;
  // bits 7:1 pattern for the unary group (low bit is w)
  localparam logic [6:0] OCD_UNARY_GRP    = 7'h7B;

  // field positions in the first and second byte
  localparam int OCD_W_BIT  = 0;
  localparam int OCD_D_BIT  = 1;
  localparam int OCD_REG_LO = 3;
  localparam int OCD_MOD_LO = 6;

  typedef enum logic [4:0] {
    OCD_OP_NONE        = 5'h00,
    OCD_OP_COPY_TO_SEG = 5'h01,
    OCD_OP_COPY_FR_SEG = 5'h02,
    OCD_OP_LOOKUP      = 5'h03,
    OCD_OP_EA_LOAD     = 5'h04,
    OCD_OP_FAR_DSEG    = 5'h05,
    OCD_OP_FAR_ESEG    = 5'h06,
    OCD_OP_FLAGS_ACC   = 5'h07,
    OCD_OP_ACC_FLAGS   = 5'h08,
    OCD_OP_SUM         = 5'h09,
    OCD_OP_SUM_CARRY   = 5'h0A,
    OCD_OP_DIFF        = 5'h0B,
    OCD_OP_DIFF_BORROW = 5'h0C,
    OCD_OP_COMPARE     = 5'h0D,
    OCD_OP_UNP_SUM     = 5'h0E,
    OCD_OP_BCD_SUM     = 5'h0F,
    OCD_OP_UNP_DIFF    = 5'h10,
    OCD_OP_BCD_DIFF    = 5'h11,
    OCD_OP_UNP_PROD    = 5'h12,
    OCD_OP_UNP_QUOT    = 5'h13,
    OCD_OP_INVERT      = 5'h14,
    OCD_OP_SIGN_CHANGE = 5'h15,
    OCD_OP_UPROD       = 5'h16,
    OCD_OP_SPROD       = 5'h17,
    OCD_OP_UQUOT       = 5'h18,
    OCD_OP_SQUOT       = 5'h19,
    OCD_OP_BYTE_EXT    = 5'h1A,
    OCD_OP_WORD_EXT    = 5'h1B,
    OCD_OP_SHIFT_ROT   = 5'h1C,
    OCD_OP_IMM_ARITH   = 5'h1D,
    OCD_OP_ILLEGAL     = 5'h1F
  } ocd_op_e;

  // shift/rotate selector, the middle field value itself
  typedef enum logic [2:0] {
    OCD_SR_LROT     = 3'h0,
    OCD_SR_RROT     = 3'h1,
    OCD_SR_LROT_C   = 3'h2,
    OCD_SR_RROT_C   = 3'h3,
    OCD_SR_LSHIFT   = 3'h4,
    OCD_SR_RSHIFT_L = 3'h5,
    OCD_SR_RSV      = 3'h6,
    OCD_SR_RSHIFT_A = 3'h7
  } ocd_sr_e;

  // decoder states, gray along the usual path
  typedef enum logic [1:0] {
    OCD_ST_FIRST  = 2'b00,
    OCD_ST_SECOND = 2'b01
  } ocd_st_e;

endpackage

// >>> testbench/ocd_decoder_props.sv
// assertions on the instruction decoder ports
`timescale 1ns/1ps
module ocd_decoder_props
  import ocd_pkg::*;
(
  input wire logic       mclk_in,
  input wire logic       rst_in,
  input wire logic       byte_valid_in,
  input wire logic [7:0] byte_in,
  input wire logic       dec_valid_out,
  input ocd_op_e         dec_op_out,
  input ocd_sr_e         dec_sr_out,
  input wire logic       dec_word_out,
  input wire logic       dec_reg_dest_out,
  input wire logic       dec_count_reg_out,
  input wire logic       dec_sext_imm_out,
  input wire logic [1:0] dec_imm_bytes_out,
  input wire logic [1:0] dec_mode_out,
  input wire logic [2:0] dec_reg_out,
  input wire logic [2:0] dec_rm_out,
  input wire logic       dec_illegal_out
);
  logic       sec_q;
  logic       sec_d;
  logic [7:0] first_q;
  logic [7:0] first_d;
  logic       t1;
  logic       t2;

  // mirrors the byte position so each check knows which byte caused it
  function automatic logic two_byte(input logic [7:0] b);
    return b inside {8'h8E, 8'h8C, 8'h8D, 8'hC5, 8'hC4, 8'hD4, 8'hD5} ||
      b[7:2] inside {6'h00, 6'h04, 6'h0A, 6'h06, 6'h0E, 6'h20, 6'h34} ||
      b[7:1] == 7'h7B;
  endfunction

  assign t1 = byte_valid_in && !sec_q;
  assign t2 = byte_valid_in && sec_q;

  always_comb begin
    sec_d   = sec_q;
    first_d = first_q;
    if (t1) begin
      sec_d   = two_byte(byte_in);
      first_d = byte_in;
    end else if (t2) begin
      sec_d = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sec_q   <= 1'b0;
      first_q <= 8'h00;
    end else begin
      sec_q   <= sec_d;
      first_q <= first_d;
    end
  end

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  single_done_a: assert property (t1 && !two_byte(byte_in) |=>
    dec_valid_out) else $error("single byte gave no result");
  no_early_a: assert property (t1 && two_byte(byte_in) |=>
    !dec_valid_out) else $error("result before second byte");
  valid_cause_a: assert property (dec_valid_out |->
    $past(byte_valid_in)) else $error("result without a byte");
  flags_pair_a: assert property (t1 && byte_in[7:1] == 7'h4F |=>
    dec_op_out == ($past(byte_in[0]) ? OCD_OP_FLAGS_ACC : OCD_OP_ACC_FLAGS))
    else $error("flags copy direction wrong");
  sum_fields_a: assert property (t2 && first_q[7:2] == 6'h00 |=>
    dec_op_out == OCD_OP_SUM && dec_word_out == $past(first_q[0]) &&
    dec_reg_dest_out == $past(first_q[1]) && dec_rm_out == $past(byte_in[2:0]))
    else $error("sum form fields wrong");
  shift_count_a: assert property (t2 && first_q[7:2] == 6'h34 &&
    byte_in[5:3] != 3'h6 |=> dec_count_reg_out == $past(first_q[1]) &&
    dec_sr_out == $past(byte_in[5:3])) else $error("shift count or kind");
  imm_bytes_a: assert property (t2 && first_q[7:2] == 6'h20 |=>
    dec_imm_bytes_out == ($past(first_q[1:0]) == 2'h1 ? 2'h2 : 2'h1))
    else $error("immediate byte count wrong");
  unary_kind_a: assert property (t2 && first_q[7:1] == 7'h7B &&
    byte_in[5:4] != 2'h0 |=> dec_op_out == 5'h12 + $past(byte_in[5:3]) &&
    dec_word_out == $past(first_q[0])) else $error("unary kind wrong");
  adjust_base_a: assert property (t2 && first_q[7:1] == 7'h6A |=>
    dec_illegal_out == ($past(byte_in) != 8'h0A)) else $error("adjust base");

  cover property (t2 && first_q[7:2] == 6'h34);
  cover property (dec_illegal_out);
  cover property (t1 ##1 t1 ##1 t1);
endmodule

bind ocd_decoder ocd_decoder_props u_props (
  .mclk_in(mclk_in), .rst_in(rst_in), .byte_valid_in(byte_valid_in),
  .byte_in(byte_in), .dec_valid_out(dec_valid_out), .dec_op_out(dec_op_out),
  .dec_sr_out(dec_sr_out), .dec_word_out(dec_word_out),
  .dec_reg_dest_out(dec_reg_dest_out), .dec_rm_out(dec_rm_out),
  .dec_count_reg_out(dec_count_reg_out), .dec_reg_out(dec_reg_out),
  .dec_sext_imm_out(dec_sext_imm_out), .dec_mode_out(dec_mode_out),
  .dec_imm_bytes_out(dec_imm_bytes_out), .dec_illegal_out(dec_illegal_out)
);

// >>> testbench/ocd_fetch_model.sv
// behavioural fetch queue handing instruction bytes to the decoder
`timescale 1ns/1ps
module ocd_fetch_model (
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  output logic            byte_valid_out,
  output logic [7:0]      byte_out
);
  logic [7:0] q[$];
  logic [7:0] prev = 8'h00;
  int         gap = 0;
  int         idle = 0;

  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask

  initial begin
    byte_valid_out = 1'b0;
    byte_out       = 8'hFF;
  end

  // gap idle cycles after each byte model a slow prefetch
  always @(posedge mclk_in) begin
    #1;
    if (!rst_in && q.size() > 0 && idle == 0) begin
      byte_out       = q.pop_front();
      byte_valid_out = 1'b1;
      prev           = byte_out;
      idle           = gap;
    end else begin
      // inverted stale byte, so an idle cycle never passes for data
      byte_out       = ~prev;
      byte_valid_out = 1'b0;
      if (idle > 0) begin
        idle--;
      end
    end
  end
endmodule

// >>> testbench/tb_ocd_decoder.sv
// self-checking bench for the instruction decoder
`timescale 1ns/1ps
module tb_ocd_decoder
  import ocd_pkg::*;
;
  logic       mclk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic       bvalid;
  logic [7:0] bdata;
  logic       d_valid;
  ocd_op_e    d_op;
  ocd_sr_e    d_sr;
  logic       d_word;
  logic       d_dest;
  logic       d_cnt;
  logic       d_sext;
  logic [1:0] d_imm;
  logic [1:0] d_mode;
  logic [2:0] d_reg;
  logic [2:0] d_rm;
  logic       d_ill;
  int         n_fail = 0;
  int         n_compared = 0;

  always #2.5 mclk_in = ~mclk_in;

  ocd_fetch_model fetch (.mclk_in(mclk_in), .rst_in(rst_in),
    .byte_valid_out(bvalid), .byte_out(bdata));

  ocd_decoder dut (.mclk_in(mclk_in), .rst_in(rst_in),
    .byte_valid_in(bvalid), .byte_in(bdata), .dec_valid_out(d_valid),
    .dec_op_out(d_op), .dec_sr_out(d_sr), .dec_word_out(d_word),
    .dec_reg_dest_out(d_dest), .dec_count_reg_out(d_cnt),
    .dec_sext_imm_out(d_sext), .dec_imm_bytes_out(d_imm),
    .dec_mode_out(d_mode), .dec_reg_out(d_reg), .dec_rm_out(d_rm),
    .dec_illegal_out(d_ill));

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic push2(input logic [7:0] a, input logic [7:0] b);
    fetch.push(a);
    fetch.push(b);
  endtask

  // results may come back to back, so each call takes the next pulse
  task automatic expect_op(input ocd_op_e op, input logic ill);
    int k;
    k = 0;
    do begin
      // look once the edge has settled the registered outputs
      @(posedge mclk_in);
      #1;
      k++;
    end while (d_valid !== 1'b1 && k < 64);
    check(8'(d_valid), 8'h01);
    check(8'(d_op), 8'(op));
    check(8'(d_ill), 8'(ill));
  endtask

  task automatic chk_f(input logic [7:0] m);
    check(8'(d_mode), 8'(m[7:6]));
    check(8'(d_reg), 8'(m[5:3]));
    check(8'(d_rm), 8'(m[2:0]));
  endtask

  task automatic t_single();
    logic [7:0] b[10] = '{8'hD7, 8'h9F, 8'h9E, 8'h37, 8'h27, 8'h3F, 8'h2F,
                          8'h98, 8'h99, 8'hF4};
    ocd_op_e    e[10] = '{OCD_OP_LOOKUP, OCD_OP_FLAGS_ACC, OCD_OP_ACC_FLAGS,
                          OCD_OP_UNP_SUM, OCD_OP_BCD_SUM, OCD_OP_UNP_DIFF,
                          OCD_OP_BCD_DIFF, OCD_OP_BYTE_EXT, OCD_OP_WORD_EXT,
                          OCD_OP_ILLEGAL};
    foreach (b[i]) fetch.push(b[i]);
    foreach (b[i]) begin
      expect_op(e[i], i == 9);
      check(8'(d_word), 8'h00);
    end
  endtask

  task automatic t_pairs();
    logic [7:0] a[9] = '{8'h8E, 8'h8C, 8'h8E, 8'h8D, 8'hC5, 8'hC4, 8'hD4,
                         8'hD5, 8'hD4};
    logic [7:0] b[9] = '{8'hD8, 8'h06, 8'h20, 8'h5A, 8'h5A, 8'h5A, 8'h0A,
                         8'h0A, 8'h0B};
    ocd_op_e    e[9] = '{OCD_OP_COPY_TO_SEG, OCD_OP_COPY_FR_SEG,
                         OCD_OP_ILLEGAL, OCD_OP_EA_LOAD, OCD_OP_FAR_DSEG,
                         OCD_OP_FAR_ESEG, OCD_OP_UNP_PROD, OCD_OP_UNP_QUOT,
                         OCD_OP_ILLEGAL};
    fetch.gap = 2;
    foreach (a[i]) push2(a[i], b[i]);
    foreach (a[i]) begin
      expect_op(e[i], i % 6 == 2);
      if (i < 6 && i != 2) begin
        chk_f(b[i]);
      end
      if (i < 2) begin
        check(8'(d_word), 8'h01);
      end
    end
    fetch.gap = 0;
  endtask

  task automatic t_regform();
    logic [5:0] p[5] = '{6'h00, 6'h04, 6'h0A, 6'h06, 6'h0E};
    ocd_op_e    e[5] = '{OCD_OP_SUM, OCD_OP_SUM_CARRY, OCD_OP_DIFF,
                         OCD_OP_DIFF_BORROW, OCD_OP_COMPARE};
    for (int i = 0; i < 20; i++) push2({p[i / 4], 2'(i)}, 8'h9D);
    for (int i = 0; i < 20; i++) begin
      expect_op(e[i / 4], 1'b0);
      check(8'(d_word), 8'(i % 2));
      check(8'(d_dest), 8'(i / 2 % 2));
      chk_f(8'h9D);
    end
  endtask

  task automatic t_unary();
    ocd_op_e e[8] = '{OCD_OP_ILLEGAL, OCD_OP_ILLEGAL, OCD_OP_INVERT,
                      OCD_OP_SIGN_CHANGE, OCD_OP_UPROD, OCD_OP_SPROD,
                      OCD_OP_UQUOT, OCD_OP_SQUOT};
    for (int i = 0; i < 16; i++) push2({7'h7B, 1'(i / 8)}, {2'h3, 3'(i), 3'h1});
    for (int i = 0; i < 16; i++) begin
      expect_op(e[i % 8], i % 8 < 2);
      if (i % 8 >= 2) begin
        check(8'(d_word), 8'(i / 8));
      end
    end
  endtask

  task automatic t_shift();
    for (int i = 0; i < 32; i++) push2({6'h34, 2'(i / 8)}, {2'h3, 3'(i), 3'h1});
    for (int i = 0; i < 32; i++) begin
      expect_op(i % 8 == 6 ? OCD_OP_ILLEGAL : OCD_OP_SHIFT_ROT,
                i % 8 == 6);
      if (i % 8 != 6) begin
        check(8'(d_sr), 8'(i % 8));
        check(8'(d_cnt), 8'(i / 16));
        check(8'(d_word), 8'(i / 8 % 2));
      end
    end
  endtask

  task automatic t_imm();
    for (int i = 0; i < 4; i++) push2({6'h20, 2'(i)}, 8'h2E);
    for (int i = 0; i < 4; i++) begin
      expect_op(OCD_OP_IMM_ARITH, 1'b0);
      check(8'(d_sext), 8'(i / 2));
      check(8'(d_imm), i == 1 ? 8'h02 : 8'h01);
      check(8'(d_word), 8'(i % 2));
      chk_f(8'h2E);
    end
  endtask

  // reset between the two bytes must drop the half-decoded instruction
  task automatic t_reset();
    fetch.push(8'h8D);
    repeat (3) @(posedge mclk_in);
    #1 rst_in = 1'b1;
    @(posedge mclk_in);
    check(8'(d_op), 8'h00);
    check(8'(d_valid), 8'h00);
    check(8'(d_word), 8'h00);
    #1 rst_in = 1'b0;
    fetch.push(8'hD7);
    expect_op(OCD_OP_LOOKUP, 1'b0);
  endtask

  initial begin
    repeat (8) @(posedge mclk_in);
    #1 rst_in = 1'b0;
    t_single();
    t_pairs();
    t_regform();
    t_unary();
    t_shift();
    t_imm();
    t_reset();
    wrap_up();
  end

  initial begin
    #20000;
    n_fail++;
    $display("unexpected at %0t: run did not finish", $time);
    wrap_up();
  end
endmodule
